/* hw/ctp_pkg.sv */
// Package with constants and types for the counter/timer pair.
package ctp_pkg;

	localparam logic [1:0] CTP_MODE_13BIT  = 2'h0;
	localparam logic [1:0] CTP_MODE_16BIT  = 2'h1;
	localparam logic [1:0] CTP_MODE_RELOAD = 2'h2;
	localparam logic [1:0] CTP_MODE_SPLIT  = 2'h3;

	localparam logic [1:0] CTP_SCALE_DIV12 = 2'h0;
	localparam logic [1:0] CTP_SCALE_DIV4  = 2'h1;
	localparam logic [1:0] CTP_SCALE_DIV48 = 2'h2;
	localparam logic [1:0] CTP_SCALE_EXT8  = 2'h3;

	localparam logic [5:0] CTP_PRESC_LAST  = 6'h2F;
	localparam logic [5:0] CTP_PRESC_RESET = 6'h00;
	localparam logic [2:0] CTP_EXT_LAST    = 3'h7;
	localparam logic [2:0] CTP_EXT_RESET   = 3'h0;

	localparam logic [15:0] CTP_COUNT_RESET = 16'h0000;
	localparam logic [12:0] CTP_MAX13       = 13'h1FFF;
	localparam logic [15:0] CTP_MAX16       = 16'hFFFF;
	localparam logic [7:0]  CTP_MAX8        = 8'hFF;
	localparam int          CTP_LO13_BITS   = 5;

	typedef struct packed {
		logic       run;
		logic       gate_enable;
		logic       gate_polarity;
		logic       count_source;
		logic       clock_select;
		logic       irq_enable;
		logic [1:0] mode;
	} ctp_cfg_t;

	typedef struct packed {
		logic       wr_low;
		logic       wr_high;
		logic [7:0] data;
	} ctp_wr_t;

	typedef struct packed {
		logic        ovf;
		logic [15:0] cnt;
	} ctp_step_t;

endpackage : ctp_pkg

/* hw/ctp_prescaler.sv */
// Prescaled clock enable generator for the counter/timer pair.
module ctp_prescaler (
	input  wire logic       sys_clk,
	input  wire logic       arst_n,
	input  wire logic [1:0] clock_scale_field,
	input  wire logic       ext_osc,
	output logic            presc_tick
);
	import ctp_pkg::*;

	logic [5:0] div_q;
	logic [2:0] ext_cnt_q;
	logic       ext_prev_q;
	logic       ext_rise;
	logic       ext_tick;

	// One counter modulo 48 gives the divide by 4, 12 and 48 enables.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			div_q <= CTP_PRESC_RESET;
		end else if (div_q == CTP_PRESC_LAST) begin
			div_q <= CTP_PRESC_RESET;
		end else begin
			div_q <= div_q + 6'h01;
		end
	end

	// The oscillator level is used unsampled; only its previous level is kept on the system clock.
	assign ext_rise = ext_osc & ~ext_prev_q;
	assign ext_tick = ext_rise && (ext_cnt_q == CTP_EXT_LAST);

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ext_prev_q <= 1'b0;
			ext_cnt_q  <= CTP_EXT_RESET;
		end else begin
			ext_prev_q <= ext_osc;
			if (ext_rise) begin
				ext_cnt_q <= ext_cnt_q + 3'h1;
			end
		end
	end

	// Scale selection.
	always_comb begin
		unique case (clock_scale_field)
			CTP_SCALE_DIV12: presc_tick = (div_q == 6'h0B) || (div_q == 6'h17)
				|| (div_q == 6'h23) || (div_q == CTP_PRESC_LAST);
			CTP_SCALE_DIV4:  presc_tick = (div_q[1:0] == 2'h3);
			CTP_SCALE_DIV48: presc_tick = (div_q == CTP_PRESC_LAST);
			CTP_SCALE_EXT8:  presc_tick = ext_tick;
		endcase
	end

endmodule : ctp_prescaler

/* hw/ctp_top.sv */
// Two classic counter/timers, A with four modes and B with three (mode 3 holds B), gating and overflow flags.
module ctp_top (
	input  wire logic              sys_clk,
	input  wire logic              arst_n,
	input  wire ctp_pkg::ctp_cfg_t timer_a_cfg,
	input  wire ctp_pkg::ctp_cfg_t timer_b_cfg,
	input  wire logic [1:0]        clock_scale_field,
	input  wire logic              ext_osc,
	input  wire logic              timer_a_event_pin,
	input  wire logic              timer_b_event_pin,
	input  wire logic              timer_a_gate_input,
	input  wire logic              timer_b_gate_input,
	input  wire ctp_pkg::ctp_wr_t  timer_a_wr,
	input  wire ctp_pkg::ctp_wr_t  timer_b_wr,
	input  wire logic              timer_a_flag_clear,
	input  wire logic              timer_b_flag_clear,
	output logic [7:0]             timer_a_low_byte,
	output logic [7:0]             timer_a_high_byte,
	output logic [7:0]             timer_b_low_byte,
	output logic [7:0]             timer_b_high_byte,
	output logic                   timer_a_overflow_flag,
	output logic                   timer_b_overflow_flag,
	output logic                   timer_a_irq,
	output logic                   timer_b_irq,
	output logic                   timer_a_ovf_pulse,
	output logic                   timer_b_ovf_pulse
);
	import ctp_pkg::*;

	logic [15:0] cnt_a_q;
	logic [15:0] cnt_b_q;
	logic [15:0] cnt_a_d;
	logic [15:0] cnt_b_d;
	logic        flag_a_q;
	logic        flag_b_q;
	logic        pin_a_q;
	logic        pin_b_q;
	logic        ovf_a_q;
	logic        ovf_b_q;
	logic        presc_tick;
	logic        split;
	logic        run_a;
	logic        run_b;
	logic        inc_a;
	logic        inc_b;
	logic        inc_hi;
	logic        set_a;
	logic        set_b;
	logic        hi_ovf;
	logic [7:0]  hi_next;
	ctp_step_t   step_a;
	ctp_step_t   step_b;

	ctp_prescaler u_presc (
		.sys_clk           (sys_clk),
		.arst_n            (arst_n),
		.clock_scale_field (clock_scale_field),
		.ext_osc           (ext_osc),
		.presc_tick        (presc_tick)
	);

	// Gate qualification with a selectable active level.
	function automatic logic gate_ok(input ctp_cfg_t cfg, input logic gin);
		logic active;
		active = cfg.gate_polarity ? gin : ~gin;
		return cfg.run && (!cfg.gate_enable || active);
	endfunction : gate_ok

	// Count enable from the chosen source.
	function automatic logic tick_sel(input logic ext_src, input logic csel,
		input logic fall, input logic ptick);
		return ext_src ? fall : (csel ? 1'b1 : ptick);
	endfunction : tick_sel

	// One counting step in modes 0 to 2; split mode steps the low byte only.
	function automatic ctp_step_t step(input logic [1:0] mode,
		input logic [15:0] c, input logic inc);
		ctp_step_t r;
		logic [12:0] v13;
		r.ovf = 1'b0;
		r.cnt = c;
		v13   = {c[15:8], c[4:0]};
		if (inc) begin
			unique case (mode)
				CTP_MODE_13BIT: begin
					r.ovf = (v13 == CTP_MAX13);
					v13   = v13 + 13'h0001;
					r.cnt = {v13[12:5], c[7:5], v13[4:0]};
				end
				CTP_MODE_16BIT: begin
					r.ovf = (c == CTP_MAX16);
					r.cnt = c + 16'h0001;
				end
				CTP_MODE_RELOAD: begin
					r.ovf = (c[7:0] == CTP_MAX8);
					r.cnt = {c[15:8], r.ovf ? c[15:8] : c[7:0] + 8'h01};
				end
				CTP_MODE_SPLIT: begin
					r.ovf = (c[7:0] == CTP_MAX8);
					r.cnt = {c[15:8], c[7:0] + 8'h01};
				end
			endcase
		end
		return r;
	endfunction : step

	assign split = (timer_a_cfg.mode == CTP_MODE_SPLIT);

	// Run control per timer; timer B follows its mode while A is split.
	assign run_a = gate_ok(timer_a_cfg, timer_a_gate_input);
	assign run_b = split ? (timer_b_cfg.mode != CTP_MODE_SPLIT)
		: (timer_b_cfg.mode != CTP_MODE_SPLIT)
		&& gate_ok(timer_b_cfg, timer_b_gate_input);

	assign inc_a = run_a && tick_sel(timer_a_cfg.count_source,
		timer_a_cfg.clock_select, pin_a_q & ~timer_a_event_pin,
		presc_tick);
	assign inc_b = run_b && tick_sel(timer_b_cfg.count_source && !split,
		timer_b_cfg.clock_select, pin_b_q & ~timer_b_event_pin,
		presc_tick);

	assign inc_hi = split && timer_b_cfg.run
		&& tick_sel(1'b0, timer_a_cfg.clock_select, 1'b0, presc_tick);
	assign hi_ovf  = inc_hi && (cnt_a_q[15:8] == CTP_MAX8);
	assign hi_next = inc_hi ? cnt_a_q[15:8] + 8'h01 : cnt_a_q[15:8];

	assign step_a = step(timer_a_cfg.mode, cnt_a_q, inc_a);
	assign step_b = step(timer_b_cfg.mode, cnt_b_q, inc_b);

	assign set_a = step_a.ovf;
	assign set_b = split ? hi_ovf : step_b.ovf;

	// Software byte writes win over counting; run never touches the count.
	always_comb begin
		cnt_a_d = split ? {hi_next, step_a.cnt[7:0]} : step_a.cnt;
		cnt_b_d = step_b.cnt;
		if (timer_a_wr.wr_low) begin
			cnt_a_d[7:0] = timer_a_wr.data;
		end
		if (timer_a_wr.wr_high) begin
			cnt_a_d[15:8] = timer_a_wr.data;
		end
		if (timer_b_wr.wr_low) begin
			cnt_b_d[7:0] = timer_b_wr.data;
		end
		if (timer_b_wr.wr_high) begin
			cnt_b_d[15:8] = timer_b_wr.data;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_a_q <= CTP_COUNT_RESET;
			cnt_b_q <= CTP_COUNT_RESET;
		end else begin
			cnt_a_q <= cnt_a_d;
			cnt_b_q <= cnt_b_d;
		end
	end

	// Event pins are kept one cycle back for falling edge detection.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_a_q <= 1'b1;
			pin_b_q <= 1'b1;
		end else begin
			pin_a_q <= timer_a_event_pin;
			pin_b_q <= timer_b_event_pin;
		end
	end

	// Overflow flags; a set in the clearing cycle wins.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			flag_a_q <= 1'b0;
			flag_b_q <= 1'b0;
		end else begin
			flag_a_q <= set_a || (flag_a_q && !timer_a_flag_clear);
			flag_b_q <= set_b || (flag_b_q && !timer_b_flag_clear);
		end
	end

	// Overflow pulses to the other peripherals.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ovf_a_q <= 1'b0;
			ovf_b_q <= 1'b0;
		end else begin
			ovf_a_q <= step_a.ovf;
			ovf_b_q <= step_b.ovf;
		end
	end

	assign timer_a_low_byte      = cnt_a_q[7:0];
	assign timer_a_high_byte     = cnt_a_q[15:8];
	assign timer_b_low_byte      = cnt_b_q[7:0];
	assign timer_b_high_byte     = cnt_b_q[15:8];
	assign timer_a_overflow_flag = flag_a_q;
	assign timer_b_overflow_flag = flag_b_q;
	assign timer_a_irq           = flag_a_q && timer_a_cfg.irq_enable;
	assign timer_b_irq           = flag_b_q && timer_b_cfg.irq_enable;
	assign timer_a_ovf_pulse     = ovf_a_q;
	assign timer_b_ovf_pulse     = ovf_b_q;

	a_stop_holds: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		(!timer_a_cfg.run && !split && !timer_a_wr.wr_low
			&& !timer_a_wr.wr_high) |=> $stable(cnt_a_q))
		else $error("Timer A counted while stopped.");

	a_wrap_16bit: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		(timer_a_cfg.mode == CTP_MODE_16BIT && inc_a && cnt_a_q == CTP_MAX16
			&& !timer_a_wr.wr_low && !timer_a_wr.wr_high)
		|=> (cnt_a_q == CTP_COUNT_RESET) && flag_a_q && timer_a_ovf_pulse)
		else $error("Timer A 16-bit wrap failed.");

	a_wrap_13bit: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		(timer_a_cfg.mode == CTP_MODE_13BIT && inc_a
			&& cnt_a_q[15:8] == CTP_MAX8 && cnt_a_q[4:0] == 5'h1F
			&& !timer_a_wr.wr_low && !timer_a_wr.wr_high)
		|=> cnt_a_q[15:8] == 8'h00 && cnt_a_q[4:0] == 5'h00 && flag_a_q)
		else $error("Timer A 13-bit wrap failed.");

	a_reload_low: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		(timer_b_cfg.mode == CTP_MODE_RELOAD && inc_b
			&& cnt_b_q[7:0] == CTP_MAX8 && !timer_b_wr.wr_low
			&& !timer_b_wr.wr_high && !split)
		|=> cnt_b_q[7:0] == $past(cnt_b_q[15:8])
			&& $stable(cnt_b_q[15:8]) && flag_b_q)
		else $error("Timer B reload failed.");

	a_irq_gated: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		set_a |=> timer_a_irq == timer_a_cfg.irq_enable)
		else $error("Timer A interrupt does not follow its enable.");

	a_sysclk_count: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		(timer_a_cfg.mode == CTP_MODE_16BIT && run_a
			&& !timer_a_cfg.count_source && timer_a_cfg.clock_select
			&& cnt_a_q != CTP_MAX16 && !timer_a_wr.wr_low
			&& !timer_a_wr.wr_high) |=> cnt_a_q == $past(cnt_a_q) + 16'h0001)
		else $error("Timer A missed a system clock count.");

	a_edge_count: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		(timer_a_cfg.mode == CTP_MODE_16BIT && run_a
			&& timer_a_cfg.count_source && pin_a_q && !timer_a_event_pin
			&& cnt_a_q != CTP_MAX16 && !timer_a_wr.wr_low
			&& !timer_a_wr.wr_high) |=> cnt_a_q == $past(cnt_a_q) + 16'h0001)
		else $error("Timer A missed a pin edge.");

	a_set_wins: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		(set_b && timer_b_flag_clear) |=> flag_b_q)
		else $error("Timer B overflow lost against a clear.");

	a_split_high: assert property (
		@(posedge sys_clk) disable iff (!arst_n)
		(split && !timer_b_cfg.run && !timer_a_wr.wr_high)
		|=> $stable(cnt_a_q[15:8]))
		else $error("Split upper byte ran without timer B run.");

endmodule : ctp_top

/* testbench/ctp_far_side.sv */
// Model of the event pins and gate inputs that face the timer pair.
module ctp_far_side (
	input  wire logic       sys_clk,
	input  wire logic       arst_n,
	input  wire logic       go,
	input  wire logic       sel,
	input  wire logic [7:0] edges,
	input  wire logic [1:0] gate_lvl,
	output logic      [1:0] event_pin,
	output logic      [1:0] gate_pin,
	output logic            busy
);
	logic [7:0] left_q;
	logic [1:0] ph_q;
	logic       who_q;

	assign busy = left_q != 8'h00;
	assign gate_pin = gate_lvl;

	// Each level is held two cycles, so events come at a quarter rate.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			left_q <= 8'h00;
			ph_q <= 2'h0;
			who_q <= 1'b0;
			event_pin <= 2'h3;
		end else if (go) begin
			left_q <= edges;
			ph_q <= 2'h0;
			who_q <= sel;
		end else if (busy) begin
			ph_q <= ph_q + 2'h1;
			if (ph_q == 2'h1) event_pin[who_q] <= 1'b0;
			if (ph_q == 2'h3) begin
				event_pin[who_q] <= 1'b1;
				left_q <= left_q - 8'h01;
			end
		end
	end
endmodule : ctp_far_side

/* testbench/test_ctp_top.sv */
// Self-checking bench for the counter/timer pair.
module test_ctp_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ctp_pkg::*;
	logic        sys_clk = 0, arst_n = 0, ext_osc = 0, go = 0, sel = 0;
	logic        busy;
	logic [1:0]  scale = 0, gate_lvl = 0, fc = 0, evp, gtp, fl, irq, pls;
	logic [7:0]  edges = 0, lo [2], hi [2];
	logic [15:0] s, c, msk;
	logic [16:0] e;
	logic [1:0]  m;
	logic        ie;
	ctp_cfg_t    cfg [2];
	ctp_wr_t     wr [2];
	int          err_count = 0, num_checks = 0, seed = 32'hab82, k, t, n;
	int          dv [4] = '{12, 4, 48, 48};
	logic [15:0] hot [3] = '{16'hFF1C, 16'hFFE0, 16'h00F8};

	ctp_top ctp_top_i (.sys_clk, .arst_n, .timer_a_cfg(cfg[0]),
		.timer_b_cfg(cfg[1]), .clock_scale_field(scale), .ext_osc,
		.timer_a_event_pin(evp[0]), .timer_b_event_pin(evp[1]),
		.timer_a_gate_input(gtp[0]), .timer_b_gate_input(gtp[1]),
		.timer_a_wr(wr[0]), .timer_b_wr(wr[1]),
		.timer_a_flag_clear(fc[0]), .timer_b_flag_clear(fc[1]),
		.timer_a_low_byte(lo[0]), .timer_a_high_byte(hi[0]),
		.timer_b_low_byte(lo[1]), .timer_b_high_byte(hi[1]),
		.timer_a_overflow_flag(fl[0]), .timer_b_overflow_flag(fl[1]),
		.timer_a_irq(irq[0]), .timer_b_irq(irq[1]),
		.timer_a_ovf_pulse(pls[0]), .timer_b_ovf_pulse(pls[1]));
	ctp_far_side ctp_far_side_i (.sys_clk, .arst_n, .go, .sel, .edges,
		.gate_lvl, .event_pin(evp), .gate_pin(gtp), .busy);

	always #2.5 sys_clk = ~sys_clk;
	always begin
		repeat (3) @(posedge sys_clk);
		ext_osc <= ~ext_osc;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic conclude();
		if (err_count == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : conclude

	task automatic load(input int i, input logic [15:0] v);
		@(posedge sys_clk) wr[i] <= {2'b10, v[7:0]};
		@(posedge sys_clk) wr[i] <= {2'b01, v[15:8]};
		@(posedge sys_clk) wr[i] <= '0;
	endtask : load

	task automatic run(input int i, input int cyc);
		@(posedge sys_clk) cfg[i].run <= 1'b1;
		repeat (cyc) @(posedge sys_clk);
		cfg[i].run <= 1'b0;
		@(negedge sys_clk);
	endtask : run

	task automatic clr(input int i);
		@(posedge sys_clk) fc[i] <= 1'b1;
		@(posedge sys_clk) fc[i] <= 1'b0;
		@(negedge sys_clk);
	endtask : clr

	// Steps a timer through cyc counts and returns the flag and count.
	function automatic logic [16:0] expect_run(logic [1:0] md,
			logic [15:0] st, int cyc);
		logic [15:0] v;
		logic [12:0] w;
		logic        f;
		v = st;
		f = 1'b0;
		for (int i = 0; i < cyc; i++) begin
			if (md == CTP_MODE_13BIT) begin
				w = {v[15:8], v[4:0]} + 13'h0001;
				f |= w == 13'h0000;
				v = {w[12:5], v[7:5], w[4:0]};
			end else if (md == CTP_MODE_16BIT) begin
				v = v + 16'h0001;
				f |= v == 16'h0000;
			end else if (v[7:0] == 8'hFF) begin
				v[7:0] = v[15:8];
				f = 1'b1;
			end else v[7:0] = v[7:0] + 8'h01;
		end
		return {f, v};
	endfunction : expect_run

	initial begin
		repeat (20000) @(posedge sys_clk);
		err_count++;
		conclude();
	end

	initial begin
		cfg[0] = '0;
		cfg[1] = '0;
		wr[0] = '0;
		wr[1] = '0;
		repeat (6) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(negedge sys_clk);
		chk({hi[0], lo[0]} | {hi[1], lo[1]}, 16'h0000);
		chk({fl, irq, pls}, 16'h0000);
		for (t = 0; t < 2; t++) begin
			@(posedge sys_clk) cfg[t] <= {6'b000011, CTP_MODE_16BIT};
			load(t, 16'hFFFF);
			run(t, 1);
			chk({hi[t], lo[t]}, 16'h0000);
			chk({fl[t], pls[t]}, 16'h0003);
			@(negedge sys_clk);
			chk({pls[t], irq[t]}, 16'h0001);
			@(negedge sys_clk);
			chk(pls[t], 16'h0000);
			clr(t);
			chk({fl[t], irq[t]}, 16'h0000);
		end
		@(posedge sys_clk) cfg[1] <= {6'b000010, CTP_MODE_16BIT};
		load(1, 16'hFFFF);
		@(posedge sys_clk) begin
			cfg[1].run <= 1'b1;
			fc[1] <= 1'b1;
		end
		@(posedge sys_clk) begin
			cfg[1].run <= 1'b0;
			fc[1] <= 1'b0;
		end
		@(negedge sys_clk);
		chk({hi[1], lo[1]}, 16'h0000);
		chk({fl[1], pls[1]}, 16'h0003);
		clr(1);
		repeat (12) begin
			t = $random(seed) & 1;
			m = 2'($unsigned($random(seed)) % 3);
			ie = 1'($random(seed));
			s = 16'($random(seed)) | hot[m];
			k = 1 + ($random(seed) & 31);
			@(posedge sys_clk) cfg[t] <= {5'b00001, ie, m};
			load(t, s);
			run(t, k);
			e = expect_run(m, s, k);
			msk = (m == CTP_MODE_13BIT) ? 16'hFF1F : 16'hFFFF;
			chk({hi[t], lo[t]} & msk, e[15:0] & msk);
			chk({fl[t], irq[t]}, {e[16], e[16] & ie});
			clr(t);
		end
		for (int i = 0; i < 8; i++) begin
			t = i & 1;
			@(posedge sys_clk) cfg[t] <= {2'b01, i[2], 3'b010, CTP_MODE_16BIT};
			gate_lvl[t] <= i[1];
			load(t, 16'h1234);
			run(t, 5);
			chk({hi[t], lo[t]}, (i[2] == i[1]) ? 16'h1239 : 16'h1234);
			repeat (3) @(negedge sys_clk);
			chk({hi[t], lo[t]}, (i[2] == i[1]) ? 16'h1239 : 16'h1234);
		end
		for (t = 0; t < 2; t++) begin
			@(posedge sys_clk) cfg[t] <= {6'b000100, CTP_MODE_16BIT};
			load(t, 16'h00F0);
			n = 1 + ($random(seed) & 15);
			@(posedge sys_clk);
			cfg[t].run <= 1'b1;
			sel <= t[0];
			edges <= 8'(n);
			go <= 1'b1;
			@(posedge sys_clk) go <= 1'b0;
			@(negedge sys_clk);
			for (k = 0; busy && k < 200; k++) @(negedge sys_clk);
			repeat (6) @(posedge sys_clk);
			cfg[t].run <= 1'b0;
			@(negedge sys_clk);
			chk({hi[t], lo[t]}, 16'h00F0 + 16'(n));
		end
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk) scale <= 2'(i);
			cfg[0] <= {6'b000000, CTP_MODE_16BIT};
			load(0, 16'h0000);
			run(0, 10 * dv[i]);
			c = {hi[0], lo[0]};
			chk(16'(c >= 16'h0009 && c <= 16'h000B), 16'h0001);
		end
		@(posedge sys_clk) cfg[0] <= {6'b000010, CTP_MODE_SPLIT};
		cfg[1] <= {6'b000000, CTP_MODE_SPLIT};
		load(0, 16'hFE33);
		load(1, 16'h0505);
		run(1, 2);
		chk({hi[0], lo[0]}, 16'h0033);
		chk({hi[1], lo[1]}, 16'h0505);
		chk({fl[0], fl[1], pls[1]}, 16'h0002);
		conclude();
	end
endmodule : test_ctp_top
